//--- core/psrc_defs.svh
/*
 Register offsets, field positions and reset values of the peripheral
 soft reset control block. Assumes inclusion by bare name.
*/
`ifndef PSRC_DEFS_SVH
`define PSRC_DEFS_SVH

`define PSRC_OFF_REQ_A      12'h040
`define PSRC_OFF_REQ_B      12'h044
`define PSRC_RESET_VAL      32'h0000_0000
`define PSRC_A_PWM_BIT      20
`define PSRC_A_ADC_BIT      16
`define PSRC_A_WDOG_BIT     3
`define PSRC_B_COMP_BIT     24
`define PSRC_B_TMR2_BIT     18
`define PSRC_B_TMR1_BIT     17
`define PSRC_B_TMR0_BIT     16
`define PSRC_B_SSER_BIT     4
`define PSRC_B_ASER1_BIT    1
`define PSRC_B_ASER0_BIT    0
`define PSRC_A_WR_MASK      32'h0011_0008
`define PSRC_B_WR_MASK      32'h0107_0013
`define PSRC_RESP_OKAY      2'h0
`define PSRC_RESP_SLVERR    2'h2

`endif

//--- core/psrc_mask_reg.sv
/*
 One 32-bit reset-request register with a write mask.
 Assumes the mask comes from capability and reserved-bit logic on clk.
*/
`timescale 1ns/1ns
`include "psrc_defs.svh"

module psrc_mask_reg (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   input  wire logic [3:0]  wr_strb,
   input  wire logic [31:0] wr_mask,
   output logic      [31:0] value_q
);
   logic [31:0] lane_mask;

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         lane_mask[i] = wr_strb[i/8] & wr_mask[i];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         value_q <= `PSRC_RESET_VAL;
      end else if (wr_en) begin
         // Masked bits keep their value; reserved stay zero
         value_q <= (value_q & ~lane_mask) | (wr_data & lane_mask);
      end
   end
endmodule : psrc_mask_reg

//--- core/psrc_pkg.sv
/*
 Types of the peripheral soft reset control block.
 Assumes psrc_defs.svh for the numeric constants.
*/
package psrc_pkg;

   typedef struct packed {
      logic pwm;
      logic adc;
      logic wdog;
   } psrc_a_rst_t;

   typedef struct packed {
      logic       comp;
      logic [2:0] timer;
      logic       sync_serial;
      logic [1:0] async_serial;
   } psrc_b_rst_t;

endpackage : psrc_pkg

//--- core/psrc_top.sv
/*
 Peripheral soft reset control: two reset-request registers on AXI4-Lite.
 Assumes capability masks come from logic on clk; peripheral resets are
 taken by logic on the same clock.
*/
// Register access over AXI4-Lite was decided locally.
// Behaviour
// - Register A at 0x040: pulse-width bit 20, converter bit 16, watchdog bit 3.
// - Register A writes are gated by capability mask A.
// - Register B at 0x044: comparator 24, timers 18..16, sync 4, async 1..0.
// - Register B writes are gated by capability mask B.
// - Reserved bits read zero and ignore writes; software preserves them.
`timescale 1ns/1ns
`include "psrc_defs.svh"

module psrc_top (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic [11:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [11:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic [31:0]           capability_mask_a,
   input  wire logic [31:0]           capability_mask_b,
   output psrc_pkg::psrc_a_rst_t      periph_rst_a_q,
   output psrc_pkg::psrc_b_rst_t      periph_rst_b_q
);
   logic        aw_held_q;
   logic [11:0] aw_addr_q;
   logic        w_held_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        do_write;
   logic        wr_a;
   logic        wr_b;
   logic [31:0] soft_reset_request_a;
   logic [31:0] soft_reset_request_b;
   logic [31:0] wr_mask_a;
   logic [31:0] wr_mask_b;
   logic [31:0] rd_word;
   logic [1:0]  rd_resp;

   // Word indices: the two low address bits never select anything
   localparam logic [9:0] word_req_a = 10'(`PSRC_OFF_REQ_A >> 2);
   localparam logic [9:0] word_req_b = 10'(`PSRC_OFF_REQ_B >> 2);

   // Write address and data accepted in either order
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   // Ready only while slot empty and no response pending
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready)
                          && !s_axi_bvalid && !do_write;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready)
                         && !s_axi_bvalid && !do_write;
      end
   end

   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_a     = do_write && (aw_addr_q[11:2] == word_req_a);
   assign wr_b     = do_write && (aw_addr_q[11:2] == word_req_b);

   // Absent units and reserved positions never take a written value
   assign wr_mask_a = capability_mask_a & `PSRC_A_WR_MASK;
   assign wr_mask_b = capability_mask_b & `PSRC_B_WR_MASK;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Unmapped writes are answered, not dropped, so a master never hangs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bresp <= `PSRC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bresp <= (wr_a || wr_b) ? `PSRC_RESP_OKAY : `PSRC_RESP_SLVERR;
      end
   end

   psrc_mask_reg u_req_a (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_a),
      .wr_data (w_data_q),
      .wr_strb (w_strb_q),
      .wr_mask (wr_mask_a),
      .value_q (soft_reset_request_a)
   );

   psrc_mask_reg u_req_b (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_b),
      .wr_data (w_data_q),
      .wr_strb (w_strb_q),
      .wr_mask (wr_mask_b),
      .value_q (soft_reset_request_b)
   );

   // Read channel: one outstanding read, answer one cycle after accept
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   // Decode ahead of the response register keeps rdata a plain flop
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_resp = `PSRC_RESP_SLVERR;
      case (s_axi_araddr[11:2])
         word_req_a: begin
            rd_word = soft_reset_request_a;
            rd_resp = `PSRC_RESP_OKAY;
         end
         word_req_b: begin
            rd_word = soft_reset_request_b;
            rd_resp = `PSRC_RESP_OKAY;
         end
         default: begin
            rd_word = 32'h0000_0000;
            rd_resp = `PSRC_RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Payload moves only on acceptance, so it stands until rready
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PSRC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_resp;
      end
   end

   // Registered copy: reset follows the bit one edge after the register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         periph_rst_a_q <= '0;
      end else begin
         periph_rst_a_q.pwm  <= soft_reset_request_a[`PSRC_A_PWM_BIT];
         periph_rst_a_q.adc  <= soft_reset_request_a[`PSRC_A_ADC_BIT];
         periph_rst_a_q.wdog <= soft_reset_request_a[`PSRC_A_WDOG_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         periph_rst_b_q <= '0;
      end else begin
         periph_rst_b_q.comp <= soft_reset_request_b[`PSRC_B_COMP_BIT];
         periph_rst_b_q.timer <=
            soft_reset_request_b[`PSRC_B_TMR2_BIT:`PSRC_B_TMR0_BIT];
         periph_rst_b_q.sync_serial <= soft_reset_request_b[`PSRC_B_SSER_BIT];
         periph_rst_b_q.async_serial <=
            soft_reset_request_b[`PSRC_B_ASER1_BIT:`PSRC_B_ASER0_BIT];
      end
   end
endmodule : psrc_top

//--- tb/psrc_top_props.sv
/* Port checker for psrc_top, bound to the design top.
   Assumes the defines header and psrc_pkg are compiled first. */
`timescale 1ns/1ns
`include "psrc_defs.svh"
module psrc_chk (
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire logic                  s_axi_bvalid,
   input wire logic [11:0]           s_axi_araddr,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic                  s_axi_rvalid,
   input wire logic [31:0]           capability_mask_a,
   input wire logic [31:0]           capability_mask_b,
   input wire psrc_pkg::psrc_a_rst_t periph_rst_a_q,
   input wire psrc_pkg::psrc_b_rst_t periph_rst_b_q
);
   logic [31:0] img_a;
   logic [31:0] img_b;
   // Reset outputs placed at their register bit positions
   assign img_a = {11'h0, periph_rst_a_q.pwm, 3'h0, periph_rst_a_q.adc, 12'h0,
                   periph_rst_a_q.wdog, 3'h0};
   assign img_b = {7'h0, periph_rst_b_q.comp, 5'h0, periph_rst_b_q.timer, 11'h0,
                   periph_rst_b_q.sync_serial, 2'h0, periph_rst_b_q.async_serial};
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_reg_a_read:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `PSRC_OFF_REQ_A
         |=> s_axi_rdata == img_a) else $error("register a read differs from resets");
   a_mask_a_gate:
      assert property (!(|(img_a & ~$past(img_a) & ~capability_mask_a)))
         else $error("absent unit set in register a");
   a_reg_b_read:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `PSRC_OFF_REQ_B
         |=> s_axi_rdata == img_b) else $error("register b read differs from resets");
   a_mask_b_gate:
      assert property (!(|(img_b & ~$past(img_b) & ~capability_mask_b)))
         else $error("absent unit set in register b");
   a_reserved_zero:
      assert property (s_axi_rvalid |->
         (s_axi_rdata & ~(`PSRC_A_WR_MASK | `PSRC_B_WR_MASK)) == 32'h0)
         else $error("reserved bit read as one");
   a_reset_follows:
      assert property ($changed({img_a, img_b}) |-> $past(s_axi_bvalid))
         else $error("unit reset moved without a write");
endmodule : psrc_chk

bind psrc_top psrc_chk i_psrc_chk (.clk, .sys_rst, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .capability_mask_a,
   .capability_mask_b, .periph_rst_a_q, .periph_rst_b_q);

//--- tb/testbench.sv
/* Register-level bench for psrc_top over AXI4-Lite.
   Assumes the checker file is compiled with it. */
`timescale 1ns/1ns
`include "psrc_defs.svh"
module testbench;
   logic                  clk = 1'b0, sys_rst = 1'b1;
   logic [11:0]           s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0]           s_axi_wdata = 32'h0, capability_mask_a = 32'h0;
   logic [31:0]           capability_mask_b = 32'h0, e_a, e_b, ln, mb;
   logic [3:0]            s_axi_wstrb = 4'h0;
   logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                  s_axi_rvalid;
   logic [31:0]           s_axi_rdata;
   logic [1:0]            s_axi_bresp, s_axi_rresp;
   psrc_pkg::psrc_a_rst_t periph_rst_a_q;
   psrc_pkg::psrc_b_rst_t periph_rst_b_q;
   logic [31:0]           m_t [5] = '{32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h5555_5555,
                                      32'hffff_ffff};
   logic [31:0]           d_t [5] = '{32'hffff_ffff, 32'h0, 32'h0, 32'hffff_ffff,
                                      32'hffff_ffff};
   logic [3:0]            s_t [5] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h1};
   int                    err_total = 0, n_compared = 0, cyc = 0;

   psrc_top i_psrc_top (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capability_mask_a, .capability_mask_b,
      .periph_rst_a_q, .periph_rst_b_q);

   always #10 clk = ~clk;

   task conclude;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   // Each channel dropped only at the edge that takes it
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", s_axi_rdata, e);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
   endtask : rd

   // Generous ceiling; the sequence needs well under two hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         conclude();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`PSRC_OFF_REQ_A, 32'h0, `PSRC_RESP_OKAY);
      rd(`PSRC_OFF_REQ_B, 32'h0, `PSRC_RESP_OKAY);
      e_a = 32'h0;
      e_b = 32'h0;
      for (int i = 0; i < 5; i++) begin
         // Mask b differs from a in bit 16 so swapped masks show
         mb = m_t[i] ^ 32'h0001_0000;
         ln = {{8{s_t[i][3]}}, {8{s_t[i][2]}}, {8{s_t[i][1]}}, {8{s_t[i][0]}}};
         e_a = (e_a & ~(ln & m_t[i] & `PSRC_A_WR_MASK)) | (d_t[i] & ln & m_t[i] & `PSRC_A_WR_MASK);
         e_b = (e_b & ~(ln & mb & `PSRC_B_WR_MASK)) | (d_t[i] & ln & mb & `PSRC_B_WR_MASK);
         capability_mask_a <= m_t[i];
         capability_mask_b <= mb;
         wr(`PSRC_OFF_REQ_A, d_t[i], s_t[i], `PSRC_RESP_OKAY);
         wr(`PSRC_OFF_REQ_B, d_t[i], s_t[i], `PSRC_RESP_OKAY);
         rd(`PSRC_OFF_REQ_A, e_a, `PSRC_RESP_OKAY);
         rd(`PSRC_OFF_REQ_B, e_b, `PSRC_RESP_OKAY);
         chk("rst_a", {29'h0, periph_rst_a_q}, {29'h0, e_a[20], e_a[16], e_a[3]});
         chk("rst_b", {25'h0, periph_rst_b_q},
             {25'h0, e_b[24], e_b[18:16], e_b[4], e_b[1:0]});
      end
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`PSRC_OFF_REQ_A, 32'h0, `PSRC_RESP_OKAY);
      wr(12'h048, 32'hffff_ffff, 4'hf, `PSRC_RESP_SLVERR);
      rd(12'h048, 32'h0, `PSRC_RESP_SLVERR);
      rd(`PSRC_OFF_REQ_B, 32'h0, `PSRC_RESP_OKAY);
      conclude();
   end
endmodule : testbench
